// ### logic/flash_rd_seq.sv
// Serial flash read sequencer with address-mode logic and its byte FIFO
`timescale 1ns/1ps

// ----------------------------------------
// Byte FIFO between array and serialiser
// ----------------------------------------
module rd_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } fifo_regs_s;
  fifo_regs_s q;
  fifo_regs_s d;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad
    $error("rd_byte_fifo: DEPTH must be a power of two");
  end

  always_comb
  begin
    d = q;
    push = in_valid_i & q.rdy;
    pop = out_ready_i & (q.cnt != '0);
    if (flush_i)
    begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        d.mem[q.wp] = in_data_i;
        d.wp = q.wp + 1'b1;
      end
      if (pop)
        d.rp = q.rp + 1'b1;
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    d.rdy = d.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      q <= '0;
      q.rdy <= 1'b1;
    end
    else
      q <= d;
  end

  assign in_ready_o = q.rdy;
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rp];
endmodule : rd_byte_fifo

// ----------------------------------------
// Read sequencer
// ----------------------------------------
module flash_rd_seq (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Flash pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] data_line_i,
  output logic [3:0] data_line_o,
  output logic [3:0] data_line_oe_o,
  // Device state and configuration
  input wire logic busy_i,
  input wire logic quad_lines_enable_bit_i,
  input wire logic quad_wide_instruction_mode_i,
  input wire logic soft_reset_i,
  input wire logic read_param_load_i,
  input wire logic [1:0] read_param_i,
  input wire logic ext_addr_load_i,
  input wire logic [7:0] ext_addr_i,
  output logic address_size_flag_o,
  output logic [7:0] ext_addr_o,
  // Array read port
  output logic rd_active_o,
  output logic [31:0] rd_addr_o,
  input wire logic mem_valid_i,
  input wire logic [7:0] mem_data_i,
  output logic mem_ready_o
);
  typedef struct packed {
    flash_rd_pkg::pins_s s1;
    flash_rd_pkg::pins_s s2;
    flash_rd_pkg::pins_s s3;
    flash_rd_pkg::seq_state_e st;
    logic [31:0] sr;
    logic [5:0] cnt;
    flash_rd_pkg::read_cfg_s cfg;
    logic [3:0] dum;
    logic [7:0] osr;
    logic [3:0] obits;
    logic [1:0] pend;
    logic address_size_flag;
    logic [7:0] ext;
    logic [1:0] rparam;
    logic [31:0] addr;
    logic act;
    logic [3:0] dout;
    logic [3:0] oe;
  } seq_regs_s;
  seq_regs_s q;
  seq_regs_s d;
  flash_rd_pkg::read_cfg_s dec;
  logic rise;
  logic fall;
  logic pop;
  logic opc_done;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] obyte;
  logic [3:0] nbits;
  logic quad_wide_instruction_mode;

  function automatic flash_rd_pkg::read_cfg_s decode(input logic [7:0] op,
    input logic qpi_m, input logic qe, input logic address_size_flag, input logic [1:0] rp);
    flash_rd_pkg::read_cfg_s c;
    c = '0;
    c.ok = 1'b1;
    c.win = qpi_m ? 3'h4 : 3'h1;
    c.wout = c.win;
    c.abits = address_size_flag ? flash_rd_pkg::ADDR_BITS_4B : flash_rd_pkg::ADDR_BITS_3B;
    case (op)
      flash_rd_pkg::OP_READ: c.ok = !qpi_m;
      flash_rd_pkg::OP_READ_4B:
      begin
        c.ok = !qpi_m;
        c.abits = flash_rd_pkg::ADDR_BITS_4B;
      end
      flash_rd_pkg::OP_FAST:
        c.dummy = qpi_m ? {1'b0, rp, 1'b0} + flash_rd_pkg::DUMMY_QPI_BASE
                        : flash_rd_pkg::DUMMY_SPI;
      flash_rd_pkg::OP_FAST_DTR:
      begin
        c.dtr = 1'b1;
        c.dummy = flash_rd_pkg::DUMMY_DTR;
      end
      flash_rd_pkg::OP_FAST_4B:
      begin
        c.ok = !qpi_m;
        c.abits = flash_rd_pkg::ADDR_BITS_4B;
        c.dummy = flash_rd_pkg::DUMMY_SPI;
      end
      flash_rd_pkg::OP_DUAL, flash_rd_pkg::OP_DUAL_4B:
      begin
        c.ok = !qpi_m;
        c.wout = 3'h2;
        c.dummy = flash_rd_pkg::DUMMY_SPI;
        if (op == flash_rd_pkg::OP_DUAL_4B)
          c.abits = flash_rd_pkg::ADDR_BITS_4B;
      end
      flash_rd_pkg::OP_QUAD:
      begin
        c.ok = !qpi_m && qe;
        c.wout = 3'h4;
        c.dummy = flash_rd_pkg::DUMMY_SPI;
      end
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction : decode

  function automatic logic [31:0] shift_in(input logic [31:0] sr,
    input logic [3:0] io, input logic [2:0] w);
    return (w == 3'h4) ? {sr[27:0], io} : {sr[30:0], io[0]};
  endfunction : shift_in

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    pop = 1'b0;
    obyte = q.osr;
    nbits = q.obits;
    opc_done = 1'b0;
    quad_wide_instruction_mode = quad_wide_instruction_mode_i;
    rise = q.s2.sck & ~q.s3.sck;
    fall = ~q.s2.sck & q.s3.sck;
    d.s1 = '{cs_n: cs_n_i, sck: sck_i, io: data_line_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    dec = decode(q.sr[7:0], quad_wide_instruction_mode, quad_lines_enable_bit_i, q.address_size_flag, q.rparam);
    if (read_param_load_i)
      d.rparam = read_param_i;
    if (ext_addr_load_i)
      d.ext = ext_addr_i;
    if (q.s2.cs_n)
    begin
      if (q.st == flash_rd_pkg::ST_IGNORE && q.pend != 2'h0)
        d.address_size_flag = q.pend == flash_rd_pkg::PEND_ENTER;
      d.st = flash_rd_pkg::ST_IDLE;
      d.pend = 2'h0;
      d.oe = 4'h0;
      d.act = 1'b0;
    end
    else
    begin
      unique case (q.st)
        flash_rd_pkg::ST_IDLE:
        begin
          d.st = flash_rd_pkg::ST_OPC;
          d.cnt = '0;
          d.dum = '0;
          d.obits = '0;
        end
        flash_rd_pkg::ST_OPC:
          if (rise)
          begin
            d.sr = shift_in(q.sr, q.s2.io, quad_wide_instruction_mode ? 3'h4 : 3'h1);
            d.cnt = q.cnt + (quad_wide_instruction_mode ? 6'h4 : 6'h1);
          end
          else if (q.cnt == flash_rd_pkg::OPC_BITS)
          begin
            opc_done = 1'b1;
            d.cnt = '0;
            if (q.sr[7:0] == flash_rd_pkg::OP_ENTER_4B)
              d.pend = flash_rd_pkg::PEND_ENTER;
            else if (q.sr[7:0] == flash_rd_pkg::OP_EXIT_4B)
              d.pend = flash_rd_pkg::PEND_EXIT;
            if (q.sr[7:0] == flash_rd_pkg::OP_ENTER_4B ||
                q.sr[7:0] == flash_rd_pkg::OP_EXIT_4B || busy_i || !dec.ok)
              d.st = flash_rd_pkg::ST_IGNORE;
            else
            begin
              d.cfg = dec;
              d.st = flash_rd_pkg::ST_ADDR;
            end
          end
        flash_rd_pkg::ST_ADDR:
          // Opcode's last fall is not an address edge
          if (rise || (q.cfg.dtr && fall && q.cnt != 6'h00))
          begin
            d.sr = shift_in(q.sr, q.s2.io, q.cfg.win);
            d.cnt = q.cnt + {3'h0, q.cfg.win};
            if (d.cnt == q.cfg.abits)
            begin
              d.act = 1'b1;
              if (q.cfg.abits == flash_rd_pkg::ADDR_BITS_4B)
                d.addr = d.sr;
              else
                d.addr = {q.ext, d.sr[23:0]};
              if (q.address_size_flag && q.cfg.abits == flash_rd_pkg::ADDR_BITS_4B)
                d.ext = d.sr[31:24];
              d.st = (q.cfg.dummy == 4'h0) ? flash_rd_pkg::ST_DATA
                                           : flash_rd_pkg::ST_DUMMY;
            end
          end
        flash_rd_pkg::ST_DUMMY:
          if (rise)
          begin
            d.dum = q.dum + 4'h1;
            if (d.dum == q.cfg.dummy)
              d.st = flash_rd_pkg::ST_DATA;
          end
        flash_rd_pkg::ST_DATA:
          if (fall || (q.cfg.dtr && rise))
          begin
            if (q.obits == 4'h0)
            begin
              obyte = fifo_data;
              nbits = 4'h8;
              pop = 1'b1;
              d.addr = q.addr + 32'h1;
            end
            unique case (q.cfg.wout)
              3'h4:
              begin
                d.dout = obyte[7:4];
                d.oe = 4'hf;
              end
              3'h2:
              begin
                d.dout = {2'h0, obyte[7:6]};
                d.oe = 4'h3;
              end
              default:
              begin
                d.dout = {2'h0, obyte[7], 1'b0};
                d.oe = 4'h2;
              end
            endcase
            d.osr = obyte << q.cfg.wout;
            d.obits = nbits - {1'b0, q.cfg.wout};
          end
        flash_rd_pkg::ST_IGNORE:
          if (rise)
            d.pend = 2'h0;
        default: d.st = flash_rd_pkg::ST_IDLE;
      endcase
    end
    if (soft_reset_i)
    begin
      d.ext = flash_rd_pkg::EXT_ADDR_RST;
      d.rparam = flash_rd_pkg::READ_PARAM_RST;
      d.address_size_flag = flash_rd_pkg::ADS_RST;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      q <= '0;
      q.s1.cs_n <= 1'b1;
      q.s2.cs_n <= 1'b1;
      q.s3.cs_n <= 1'b1;
      q.st <= flash_rd_pkg::ST_IDLE;
      q.ext <= flash_rd_pkg::EXT_ADDR_RST;
      q.rparam <= flash_rd_pkg::READ_PARAM_RST;
      q.address_size_flag <= flash_rd_pkg::ADS_RST;
    end
    else
      q <= d;
  end

  rd_byte_fifo #(
    .WIDTH(flash_rd_pkg::FIFO_WIDTH),
    .DEPTH(flash_rd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .flush_i(q.s2.cs_n),
    .in_valid_i(mem_valid_i),
    .in_data_i(mem_data_i),
    .in_ready_o(mem_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(pop)
  );

  assign data_line_o = q.dout;
  assign data_line_oe_o = q.oe;
  assign address_size_flag_o = q.address_size_flag;
  assign ext_addr_o = q.ext;
  assign rd_active_o = q.act;
  assign rd_addr_o = q.addr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_busy;
    opc_done && busy_i && dec.ok |=> q.st == flash_rd_pkg::ST_IGNORE;
  endproperty
  a_busy: assert property (p_busy)
    else $error("read accepted while busy");

  property p_qpi_read;
    opc_done && quad_wide_instruction_mode && q.sr[7:0] == flash_rd_pkg::OP_READ |=> !q.act [*2];
  endproperty
  a_qpi_read: assert property (p_qpi_read)
    else $error("plain read accepted in quad-wide mode");

  property p_wide;
    opc_done && dec.ok && !busy_i && (q.address_size_flag || q.sr[7:0] == flash_rd_pkg::OP_READ_4B)
      |=> q.cfg.abits == flash_rd_pkg::ADDR_BITS_4B;
  endproperty
  a_wide: assert property (p_wide)
    else $error("32-bit address not selected");

  property p_dtr;
    opc_done && !busy_i && q.sr[7:0] == flash_rd_pkg::OP_FAST_DTR
      |=> q.cfg.dtr && q.cfg.dummy == 4'h6;
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("DTR fast read setup wrong");

  property p_enter;
    q.s2.cs_n && q.st == flash_rd_pkg::ST_IGNORE && q.pend == 2'h1 && !soft_reset_i
      |=> address_size_flag_o;
  endproperty
  a_enter: assert property (p_enter)
    else $error("enter wide address not taken");

  property p_exit;
    q.s2.cs_n && q.st == flash_rd_pkg::ST_IGNORE && q.pend == 2'h2
      |=> !address_size_flag_o;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit wide address not taken");

  property p_rst;
    soft_reset_i |=> (ext_addr_o == 8'h00 && q.rparam == 2'h0 && !address_size_flag_o)
      ##1 (q.ext == $past(ext_addr_o) || $past(ext_addr_load_i) || rd_active_o);
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values not restored");

  property p_upper;
    $rose(rd_active_o) && !address_size_flag_o && q.cfg.abits == 6'h18
      |-> rd_addr_o[31:24] == ext_addr_o;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper byte not from extended register");

  property p_ext_upd;
    $rose(rd_active_o) && address_size_flag_o |-> ext_addr_o == rd_addr_o[31:24];
  endproperty
  a_ext_upd: assert property (p_ext_upd)
    else $error("extended register not updated");

  property p_release;
    q.s2.cs_n |=> data_line_oe_o == 4'h0 && q.st == flash_rd_pkg::ST_IDLE && !rd_active_o;
  endproperty
  a_release: assert property (p_release)
    else $error("lines not released on deselect");

  property p_inc;
    pop |=> rd_addr_o == $past(rd_addr_o) + 32'h1;
  endproperty
  a_inc: assert property (p_inc)
    else $error("address not advanced");

  property p_underrun;
    pop |-> fifo_valid;
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("byte popped from empty buffer");

  property p_msb;
    pop && q.cfg.wout == 3'h1 |=> data_line_o[1] == $past(fifo_data[7]) && data_line_oe_o == 4'h2;
  endproperty
  a_msb: assert property (p_msb)
    else $error("byte not sent msb first");
endmodule : flash_rd_seq

// ### logic/flash_rd_pkg.sv
// Opcodes, reset values and carrier types of the flash read sequencer
package flash_rd_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ_4B = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_FAST_4B = 8'h0c;
  localparam logic [7:0] OP_FAST_DTR = 8'h0d;
  localparam logic [7:0] OP_DUAL = 8'h3b;
  localparam logic [7:0] OP_DUAL_4B = 8'h3c;
  localparam logic [7:0] OP_QUAD = 8'h6b;
  localparam logic [7:0] OP_ENTER_4B = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B = 8'he9;
  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS_3B = 6'h18;
  localparam logic [5:0] ADDR_BITS_4B = 6'h20;
  localparam logic [3:0] DUMMY_SPI = 4'h8;
  localparam logic [3:0] DUMMY_DTR = 4'h6;
  localparam logic [3:0] DUMMY_QPI_BASE = 4'h2;
  localparam logic [7:0] EXT_ADDR_RST = 8'h00;
  localparam logic [1:0] READ_PARAM_RST = 2'h0;
  localparam logic ADS_RST = 1'b0;
  localparam logic [1:0] PEND_ENTER = 2'h1;
  localparam logic [1:0] PEND_EXIT = 2'h2;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA = 3'h6,
    ST_IGNORE = 3'h4
  } seq_state_e;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } pins_s;
  typedef struct packed {
    logic ok;
    logic [2:0] win;
    logic [2:0] wout;
    logic dtr;
    logic [5:0] abits;
    logic [3:0] dummy;
  } read_cfg_s;
endpackage : flash_rd_pkg

// ### bench/flash_host_model.sv
// Host controller model that drives the flash pins
`timescale 1ns/1ps

module flash_host_model (
  // Pins towards the device
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Resolved line levels
  input wire logic [3:0] io_i
);
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h0;
    io_oe_o = 4'h0;
  end

  // One serial clock, 160 ns, idle low
  task automatic tick();
    #40;
    sck_o = 1'b1;
    #80;
    sck_o = 1'b0;
    #40;
  endtask : tick

  task automatic open_frame();
    #3;
    cs_n_o = 1'b0;
    #80;
  endtask : open_frame

  task automatic close_frame();
    #40;
    cs_n_o = 1'b1;
    io_oe_o = 4'h0;
    io_o = ~io_o;
    #200;
  endtask : close_frame

  // MSB first, one or four lanes per clock
  task automatic send(input logic [31:0] v, input int n, input int lanes);
    logic [31:0] s;
    s = v << (32 - n);
    io_oe_o = (lanes == 4) ? 4'hf : 4'h1;
    for (int i = 0; i < n; i += lanes)
    begin
      io_o = (lanes == 4) ? s[31:28] : {3'h0, s[31]};
      s = s << lanes;
      tick();
    end
  endtask : send

  // Double rate: second bit set mid-high, taken on the fall
  task automatic send_dtr(input logic [31:0] v, input int n, input int lanes);
    logic [31:0] s;
    s = v << (32 - n);
    io_oe_o = (lanes == 4) ? 4'hf : 4'h1;
    for (int i = 0; i < n; i += 2 * lanes)
    begin
      io_o = (lanes == 4) ? s[31:28] : {3'h0, s[31]};
      s = s << lanes;
      #40;
      sck_o = 1'b1;
      #40;
      io_o = (lanes == 4) ? s[31:28] : {3'h0, s[31]};
      s = s << lanes;
      #40;
      sck_o = 1'b0;
      #40;
    end
  endtask : send_dtr

  function automatic logic [7:0] take(input logic [7:0] b, input logic [3:0] io, input int lanes);
    return (lanes == 4) ? {b[3:0], io} : (lanes == 2) ? {b[5:0], io[1:0]} : {b[6:0], io[1]};
  endfunction : take

  // Lines released before the first dummy clock
  task automatic dummies(input int n);
    io_oe_o = 4'h0;
    io_o = ~io_o;
    repeat (n) tick();
  endtask : dummies

  // Sample one byte on rising edges
  task automatic recv(output logic [7:0] b, input int lanes);
    b = 8'h00;
    for (int i = 0; i < 8; i += lanes)
    begin
      #40;
      sck_o = 1'b1;
      b = take(b, io_i, lanes);
      #80;
      sck_o = 1'b0;
      #40;
    end
  endtask : recv

  // Double rate: sample on each edge
  task automatic recv_dtr(output logic [7:0] b, input int lanes);
    b = 8'h00;
    for (int i = 0; i < 8; i += 2 * lanes)
    begin
      #40;
      sck_o = 1'b1;
      b = take(b, io_i, lanes);
      #80;
      sck_o = 1'b0;
      b = take(b, io_i, lanes);
      #40;
    end
  endtask : recv_dtr
endmodule : flash_host_model

// ### bench/flash_rd_seq_test.sv
// Self-checking bench for the flash read sequencer
`timescale 1ns/1ps

module flash_rd_seq_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cs_n, sck;
  logic busy_i = 1'b0, qe_i = 1'b1, qpi_i = 1'b0;
  logic soft_reset_i = 1'b0, read_param_load_i = 1'b0, ext_addr_load_i = 1'b0;
  logic [1:0] read_param_i = 2'h0;
  logic [7:0] ext_addr_i = 8'h00, mem_data_i = 8'h00, ext_addr_o;
  logic mem_valid_i = 1'b0, arr_run = 1'b0, seen_active = 1'b0;
  logic [3:0] host_io, host_oe, data_line_o, data_line_oe_o, wire_v;
  logic [3:0] float_q = 4'h5;
  logic address_size_flag_o, rd_active_o, mem_ready_o;
  logic [31:0] rd_addr_o, arr_next, arr_start;
  int fail_count = 0;
  int check_count = 0;

  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[31:24] ^ 8'ha5;
  endfunction : pat

  flash_host_model host_u (
    .cs_n_o(cs_n), .sck_o(sck), .io_o(host_io), .io_oe_o(host_oe), .io_i(wire_v)
  );
  flash_rd_seq dut_u (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n), .sck_i(sck),
    .data_line_i(wire_v), .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o),
    .busy_i(busy_i), .quad_lines_enable_bit_i(qe_i), .quad_wide_instruction_mode_i(qpi_i),
    .soft_reset_i(soft_reset_i), .read_param_load_i(read_param_load_i),
    .read_param_i(read_param_i), .ext_addr_load_i(ext_addr_load_i), .ext_addr_i(ext_addr_i),
    .address_size_flag_o(address_size_flag_o), .ext_addr_o(ext_addr_o),
    .rd_active_o(rd_active_o), .rd_addr_o(rd_addr_o), .mem_valid_i(mem_valid_i),
    .mem_data_i(mem_data_i), .mem_ready_o(mem_ready_o)
  );

  initial
  begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Line resolution and array model
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wire_v[i] = data_line_oe_o[i] ? data_line_o[i] : (host_oe[i] ? host_io[i] : float_q[i]);
    end
  end
  always @(posedge sys_clk_i)
  begin
    float_q <= ~float_q;
  end
  always @(posedge sys_clk_i)
  begin : array_model
    logic hs, act;
    logic [31:0] start;
    hs = mem_valid_i & mem_ready_o;
    act = rd_active_o;
    start = rd_addr_o;
    #1;
    if (act !== 1'b1)
    begin
      arr_run = 1'b0;
      mem_valid_i = 1'b0;
    end
    else
    begin
      seen_active = 1'b1;
      if (!arr_run)
      begin
        arr_start = start;
        arr_next = start;
        arr_run = 1'b1;
      end
      else if (hs)
      begin
        arr_next = arr_next + 32'h1;
      end
      mem_valid_i = 1'b1;
      mem_data_i = pat(arr_next);
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic strobe(input logic [2:0] sel, input logic [7:0] v);
    @(posedge sys_clk_i);
    #1;
    {soft_reset_i, read_param_load_i, ext_addr_load_i} = sel;
    ext_addr_i = v;
    read_param_i = v[1:0];
    @(posedge sys_clk_i);
    #1;
    {soft_reset_i, read_param_load_i, ext_addr_load_i} = 3'h0;
    @(posedge sys_clk_i);
    #1;
  endtask : strobe

  task automatic set_mode(input logic [2:0] m);
    @(posedge sys_clk_i);
    #1;
    {busy_i, qe_i, qpi_i} = m;
  endtask : set_mode

  task automatic do_cmd(input logic [7:0] op);
    host_u.open_frame();
    host_u.send({24'h0, op}, 8, 1);
    host_u.close_frame();
  endtask : do_cmd

  task automatic do_read(input logic [7:0] op, input int ol, input logic [31:0] addr,
      input int ab, input int al, input int dum, input int dl, input int nb,
      input logic [31:0] exp_start, input logic [3:0] exp_oe, input bit dtr = 1'b0);
    logic [7:0] b;
    host_u.open_frame();
    host_u.send({24'h0, op}, 8, ol);
    if (dtr)
      host_u.send_dtr(addr, ab, al);
    else
      host_u.send(addr, ab, al);
    host_u.dummies(dum);
    for (int k = 0; k < nb; k++)
    begin
      if (dtr)
        host_u.recv_dtr(b, dl);
      else
        host_u.recv(b, dl);
      check(b, pat(exp_start + k));
      check(data_line_oe_o, exp_oe);
    end
    check(mem_ready_o, 1'b0);
    check(arr_start, exp_start);
    check(rd_active_o, 1'b1);
    host_u.close_frame();
    check({rd_active_o, data_line_oe_o}, 5'h00);
  endtask : do_read

  task automatic do_refused(input logic [7:0] op, input int ol);
    seen_active = 1'b0;
    host_u.open_frame();
    host_u.send({24'h0, op}, 8, ol);
    host_u.send(32'h0000_0040, 24, ol);
    host_u.dummies(16);
    check({seen_active, data_line_oe_o}, 5'h00);
    host_u.close_frame();
  endtask : do_refused

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset_values();
    check({address_size_flag_o, ext_addr_o}, 9'h000);
    check({data_line_oe_o, rd_active_o, mem_ready_o}, 6'h01);
  endtask : s_reset_values

  task automatic s_single();
    strobe(3'h1, 8'h01);
    check(ext_addr_o, 8'h01);
    do_read(flash_rd_pkg::OP_READ, 1, 32'h0012_34fe, 24, 1, 0, 1, 3, 32'h0112_34fe, 4'h2);
  endtask : s_single

  task automatic s_fast_ops();
    logic [7:0] ops [6] = '{8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b};
    int ab [6] = '{32, 24, 32, 24, 32, 24};
    int dm [6] = '{0, 8, 8, 8, 8, 8};
    int dl [6] = '{1, 1, 1, 2, 2, 4};
    logic [3:0] oe [6] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'hf};
    logic [31:0] exp;
    for (int i = 0; i < 6; i++)
    begin
      exp = (ab[i] == 32) ? 32'h02ab_cdef : 32'h01ab_cdef;
      do_read(ops[i], 1, 32'h02ab_cdef, ab[i], 1, dm[i], dl[i], 2, exp, oe[i]);
    end
    do_read(flash_rd_pkg::OP_FAST_DTR, 1, 32'h02ab_cdef, 24, 1, 6, 1, 2,
        32'h01ab_cdef, 4'h2, 1'b1);
    check(ext_addr_o, 8'h01);
  endtask : s_fast_ops

  task automatic s_refused();
    logic [7:0] ops [6] = '{8'h03, 8'h13, 8'h0c, 8'h3b, 8'h3c, 8'h6b};
    set_mode(3'h3);
    foreach (ops[i]) do_refused(ops[i], 4);
    set_mode(3'h0);
    do_refused(flash_rd_pkg::OP_QUAD, 1);
    set_mode(3'h6);
    do_refused(flash_rd_pkg::OP_READ, 1);
    set_mode(3'h2);
  endtask : s_refused

  task automatic s_addr_mode();
    do_cmd(flash_rd_pkg::OP_ENTER_4B);
    check(address_size_flag_o, 1'b1);
    do_read(flash_rd_pkg::OP_READ, 1, 32'h0300_0010, 32, 1, 0, 1, 2, 32'h0300_0010, 4'h2);
    check(ext_addr_o, 8'h03);
    do_read(flash_rd_pkg::OP_QUAD, 1, 32'h0300_0020, 32, 1, 8, 4, 2, 32'h0300_0020, 4'hf);
    do_cmd(flash_rd_pkg::OP_EXIT_4B);
    check(address_size_flag_o, 1'b0);
    do_read(flash_rd_pkg::OP_READ, 1, 32'h0000_0080, 24, 1, 0, 1, 1, 32'h0300_0080, 4'h2);
  endtask : s_addr_mode

  task automatic s_qpi_dummy();
    strobe(3'h2, 8'h03);
    strobe(3'h4, 8'h00);
    check({address_size_flag_o, ext_addr_o}, 9'h000);
    set_mode(3'h3);
    do_read(flash_rd_pkg::OP_FAST, 4, 32'h0000_0100, 24, 4, 2, 4, 2, 32'h0000_0100, 4'hf);
    for (int p = 1; p < 4; p++)
    begin
      strobe(3'h2, 8'(p));
      do_read(flash_rd_pkg::OP_FAST, 4, 32'h0000_0200, 24, 4, 2 * p + 2, 4, 2,
          32'h0000_0200, 4'hf);
    end
    do_read(flash_rd_pkg::OP_FAST_DTR, 4, 32'h0000_0300, 24, 4, 6, 4, 2,
        32'h0000_0300, 4'hf, 1'b1);
    set_mode(3'h2);
  endtask : s_qpi_dummy

  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    #1;
    arst_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    s_reset_values();
    s_single();
    s_fast_ops();
    s_refused();
    s_addr_mode();
    s_qpi_dummy();
    give_verdict();
  end

  initial
  begin
    #600000;
    fail_count++;
    give_verdict();
  end
endmodule : flash_rd_seq_test
